// >>> verilog/apc_regs.vh
// register offsets, field positions, reset values and timing counts
// included by every design file of the amplifier configuration block
`ifndef APC_REGS_VH
`define APC_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define APC_ADDR_POWER      7'h02
`define APC_ADDR_CHAN_PDN   7'h03
`define APC_ADDR_MISC       7'h04
`define APC_ADDR_RAMP       7'h05
`define APC_ADDR_VOLCFG     7'h06
`define APC_ADDR_MVOL_INT   7'h07
`define APC_ADDR_MVOL_FRAC  7'h08
`define APC_ADDR_CVOL_A1    7'h09
`define APC_ADDR_CMUTE      7'h13

// ****************************************
// field positions
// ****************************************
`define APC_BIT_SLEEP       0
`define APC_BIT_OFFSTATE    1
`define APC_BIT_FREEZE      2
`define APC_BIT_AMHOP       3
`define APC_BIT_MUTE50      3
`define APC_BIT_SHARED      7

// ****************************************
// reset values and write masks
// ****************************************
`define APC_RST_POWER       8'h01
`define APC_RST_CHAN_PDN    8'hFF
`define APC_RST_MISC        8'h20
`define APC_RST_RAMP        8'h01
`define APC_RST_VOLCFG      8'h40
`define APC_MASK_POWER      8'h03
`define APC_MASK_CHAN_PDN   8'h3F
`define APC_MASK_MISC       8'hEF
`define APC_MASK_RAMP       8'h1B
`define APC_MASK_VOLCFG     8'hE8

// ****************************************
// modes
// ****************************************
`define APC_RAMP_NONE       2'h0
`define APC_RAMP_DOWN       2'h1
`define APC_RAMP_BOTH       2'h3
`define APC_LCM_IMMED       2'h0
`define APC_LCM_ZC          2'h1
`define APC_LCM_SOFT        2'h2
`define APC_LCM_SOFTZC      2'h3

// ****************************************
// timing (ref clock 250 MHz)
// ****************************************
`define APC_CLK_MHZ         250
`define APC_RAMP_MS_0       100
`define APC_RAMP_MS_1       200
`define APC_RAMP_MS_2       300
`define APC_RAMP_MS_3       650
`define APC_ZC_US_SLOW      18700
`define APC_ZC_US_FAST      17000
`define APC_ZC_CYC_SLOW     (`APC_ZC_US_SLOW * `APC_CLK_MHZ)
`define APC_ZC_CYC_FAST     (`APC_ZC_US_FAST * `APC_CLK_MHZ)
`define APC_DUTY_MAX        8'hFF
`define APC_DUTY_HALF       8'h80

`endif

// >>> verilog/apc_chan_ramp.v
// one output channel: bias ramp to and from 50% duty, sleep drive
// assumes a pwm count enable and a duty target from the audio duty path
`timescale 1ns/1ns
`include "apc_regs.vh"

module apc_chan_ramp #(
   parameter STEP_W = 24
) (
   input  wire              refClk,
   input  wire              resetN,
   input  wire              sleep,
   input  wire              offState,
   input  wire [1:0]        rampSel,
   input  wire [STEP_W-1:0] stepCycles,
   input  wire [7:0]        audioDuty,
   input  wire              dutyStrobe,
   output reg               posPulse,
   output reg               negPulse,
   output reg               active
);

   localparam ST_OFF  = 2'h0;
   localparam ST_UP   = 2'h1;
   localparam ST_RUN  = 2'h2;
   localparam ST_DOWN = 2'h3;

   reg [1:0]        state;
   reg [7:0]        rampDuty;
   reg [STEP_W-1:0] stepCnt;
   reg [7:0]        pwmCnt;
   reg [1:0]        next_state;
   reg [7:0]        duty;

   wire upEn   = (rampSel == `APC_RAMP_BOTH);
   wire downEn = (rampSel == `APC_RAMP_BOTH) || (rampSel == `APC_RAMP_DOWN);
   wire stepHit = (stepCnt >= stepCycles);

   // ****************************************
   // ramp state
   // ****************************************
   always @* begin
      next_state = state;
      case (state)
         ST_OFF:  if (!sleep) next_state = upEn ? ST_UP : ST_RUN;
         ST_UP:   if (sleep) next_state = downEn ? ST_DOWN : ST_OFF;
                  else if (rampDuty == `APC_DUTY_HALF && stepHit &&
                           rampSel == `APC_RAMP_DOWN)
                     next_state = ST_RUN;
         ST_RUN:  if (sleep) next_state = downEn ? ST_DOWN : ST_OFF;
         ST_DOWN: if (rampDuty == 8'h00 && stepHit) next_state = ST_OFF;
         default: next_state = ST_OFF;
      endcase
   end

   always @(posedge refClk or negedge resetN) begin
      if (!resetN) begin
         state    <= ST_OFF;
         rampDuty <= 8'h00;
         stepCnt  <= {STEP_W{1'b0}};
      end else begin
         state   <= next_state;
         stepCnt <= (stepHit || state == ST_OFF || state == ST_RUN) ?
                    {STEP_W{1'b0}} : stepCnt + 1'b1;
         if (state == ST_RUN)
            rampDuty <= `APC_DUTY_HALF;
         else if (state == ST_OFF)
            rampDuty <= 8'h00;
         else if (stepHit && state == ST_UP && rampDuty != `APC_DUTY_HALF)
            rampDuty <= rampDuty + 8'h01;
         else if (stepHit && state == ST_DOWN && rampDuty != 8'h00)
            rampDuty <= rampDuty - 8'h01;
      end
   end

   // ****************************************
   // pwm output
   // ****************************************
   always @* begin
      duty = (state == ST_RUN) ? audioDuty : rampDuty;
   end

   always @(posedge refClk or negedge resetN) begin
      if (!resetN) begin
         pwmCnt   <= 8'h00;
         posPulse <= 1'b0;
         negPulse <= 1'b0;
         active   <= 1'b0;
      end else begin
         // one pwm count per enable, wraps every 256 counts
         pwmCnt <= dutyStrobe ? pwmCnt + 8'h01 : pwmCnt;
         active <= (state != ST_OFF);
         if (state == ST_OFF) begin
            posPulse <= 1'b0;
            negPulse <= offState;
         end else begin
            posPulse <= (pwmCnt < duty);
            negPulse <= !(pwmCnt < duty);
         end
      end
   end

endmodule // apc_chan_ramp

// >>> verilog/apc_level_track.v
// one channel level tracker: immediate, zero cross, soft ramp modes
// levels in eighth-dB units, lrTick is one per left/right period
`timescale 1ns/1ns
`include "apc_regs.vh"

module apc_level_track #(
   parameter TO_W = 23
) (
   input  wire            refClk,
   input  wire            resetN,
   input  wire [11:0]     target,
   input  wire [1:0]      mode,
   input  wire            lrTick,
   input  wire            zeroCross,
   input  wire [TO_W-1:0] timeout,
   output reg  [11:0]     level
);

   reg [TO_W-1:0] toCnt;
   wire differs   = (level != target);
   wire zcOk      = zeroCross || (toCnt >= timeout);
   wire up        = ($signed(target) > $signed(level));
   wire [11:0] stepped = up ? level + 12'h001 : level - 12'h001;

   // ****************************************
   // level update
   // ****************************************
   always @(posedge refClk or negedge resetN) begin
      if (!resetN) begin
         level <= 12'h000;
         toCnt <= {TO_W{1'b0}};
      end else begin
         toCnt <= (!differs || zcOk) ? {TO_W{1'b0}} : toCnt + 1'b1;
         case (mode)
            `APC_LCM_IMMED:  level <= target;
            `APC_LCM_ZC:     if (differs && zcOk)
                                level <= target;
            `APC_LCM_SOFT:   if (differs && lrTick)
                                level <= stepped;
            `APC_LCM_SOFTZC: if (differs && zcOk)
                                level <= stepped;
            default:         level <= target;
         endcase
      end
   end

endmodule // apc_level_track

// >>> verilog/apc_config_top.v
// amplifier power, ramp and volume behaviour configuration bank
// registers reached over a byte-wide control port, one clock domain
`timescale 1ns/1ns
`include "apc_regs.vh"

module apc_config_top #(
   parameter NCH     = 6,
   parameter STEP_W  = 24,
   parameter TO_W    = 23,
   parameter ZC_SLOW = `APC_ZC_CYC_SLOW,
   parameter ZC_FAST = `APC_ZC_CYC_FAST
) (
   input  wire             ref_clk,
   input  wire             reset_n,
   input  wire [6:0]       regAddr,
   input  wire             regWrite,
   input  wire             regRead,
   input  wire [7:0]       regWdata,
   output reg  [7:0]       regRdata,
   input  wire             lrTick,
   input  wire [NCH-1:0]   zeroCross,
   input  wire [NCH*8-1:0] audioDuty,
   input  wire [NCH*8-1:0] supplyCorr,
   input  wire             supplyRejectEn,
   input  wire [NCH-1:0]   muteReq,
   output reg  [NCH-1:0]   posPulseOut,
   output reg  [NCH-1:0]   negPulseOut,
   output reg              deviceAwake,
   output reg  [2:0]       audioFormatSel,
   output reg  [1:0]       emphasisFilterSel,
   output reg              amBandHopEn,
   output reg  [NCH*12-1:0] chanLevel
);

   // ****************************************
   // register storage
   // ****************************************
   reg [7:0]       powerReg;
   reg [7:0]       chanPdnReg;
   reg [7:0]       miscReg;
   reg [7:0]       rampReg;
   reg [7:0]       volCfgReg;
   reg [7:0]       mvolInt;
   reg [1:0]       mvolFrac;
   reg [7:0]       cvolInt [0:NCH-1];
   reg [NCH-1:0]   cmuteReg;
   // applied copies, held while frozen
   reg [9:0]       mvolApplied;
   reg [7:0]       cvolApplied [0:NCH-1];
   reg [NCH-1:0]   cmuteApplied;
   reg [7:0]       dutyStrobeCnt;
   integer         i;
   integer         j;
   integer         k;

   // ****************************************
   // field decode
   // ****************************************
   wire globalSleep = powerReg[`APC_BIT_SLEEP];
   wire offState    = powerReg[`APC_BIT_OFFSTATE];
   wire freeze      = miscReg[`APC_BIT_FREEZE];
   wire sharedLevel = volCfgReg[`APC_BIT_SHARED];
   wire mute50      = volCfgReg[`APC_BIT_MUTE50];
   wire [1:0] lcMode   = volCfgReg[6:5];
   wire [1:0] rampSel  = rampReg[4:3];
   wire [1:0] rampSpd  = rampReg[1:0];
   wire hopOn          = miscReg[`APC_BIT_AMHOP];
   wire dutyStrobe     = (dutyStrobeCnt == 8'h00);

   // ****************************************
   // helper functions
   // ****************************************
   localparam [7:0] VOL_MAX = 8'h18;

   // integer volume above +24 dB acts as +24 dB
   function [7:0] clampVol;
      input [7:0] v;
      begin
         if (!v[7] && v > VOL_MAX)
            clampVol = VOL_MAX;
         else
            clampVol = v;
      end
   endfunction

   // duty plus correction, held at full scale
   function [7:0] satAdd;
      input [7:0] a;
      input [7:0] b;
      reg   [8:0] s;
      begin
         s      = {1'b0, a} + {1'b0, b};
         satAdd = s[8] ? `APC_DUTY_MAX : s[7:0];
      end
   endfunction

   function [STEP_W-1:0] stepFor;
      input [1:0] spd;
      reg [31:0] ms;
      reg [31:0] cyc;
      begin
         case (spd)
            2'h0:    ms = `APC_RAMP_MS_0;
            2'h1:    ms = `APC_RAMP_MS_1;
            2'h2:    ms = `APC_RAMP_MS_2;
            default: ms = `APC_RAMP_MS_3;
         endcase
         // 128 duty steps cover the ramp from zero to half
         cyc     = ms * 32'd1000 * `APC_CLK_MHZ / 32'd128;
         stepFor = cyc[STEP_W-1:0];
      end
   endfunction

   // one pwm count per 4 clocks, per 9 with hop on: rate / 2.25
   wire [7:0] strobeLast = hopOn ? 8'h08 : 8'h03;

   // ****************************************
   // register write port
   // ****************************************
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         powerReg   <= `APC_RST_POWER;
         chanPdnReg <= `APC_RST_CHAN_PDN;
         miscReg    <= `APC_RST_MISC;
         rampReg    <= `APC_RST_RAMP;
         volCfgReg  <= `APC_RST_VOLCFG;
         mvolInt    <= 8'h00;
         mvolFrac   <= 2'h0;
         cmuteReg   <= {NCH{1'b0}};
         for (i = 0; i < NCH; i = i + 1)
            cvolInt[i] <= 8'h00;
      end else if (regWrite) begin
         case (regAddr)
            `APC_ADDR_POWER:    powerReg   <= regWdata & `APC_MASK_POWER;
            `APC_ADDR_CHAN_PDN: chanPdnReg <= regWdata & `APC_MASK_CHAN_PDN;
            `APC_ADDR_MISC:     miscReg    <= regWdata & `APC_MASK_MISC;
            `APC_ADDR_RAMP:     rampReg    <= regWdata & `APC_MASK_RAMP;
            `APC_ADDR_VOLCFG:   volCfgReg  <= regWdata & `APC_MASK_VOLCFG;
            `APC_ADDR_MVOL_INT: mvolInt    <= regWdata;
            `APC_ADDR_MVOL_FRAC: mvolFrac  <= regWdata[1:0];
            `APC_ADDR_CMUTE:    cmuteReg   <= regWdata[NCH-1:0];
            default: begin
               for (i = 0; i < NCH; i = i + 1)
                  if (regAddr == `APC_ADDR_CVOL_A1 + i[6:0])
                     cvolInt[i] <= regWdata;
            end
         endcase
      end
   end // reserved bits masked

   // ****************************************
   // register read port
   // ****************************************
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         case (regAddr)
            `APC_ADDR_POWER:     regRdata <= powerReg;
            `APC_ADDR_CHAN_PDN:  regRdata <= chanPdnReg;
            `APC_ADDR_MISC:      regRdata <= miscReg;
            `APC_ADDR_RAMP:      regRdata <= rampReg;
            `APC_ADDR_VOLCFG:    regRdata <= volCfgReg;
            `APC_ADDR_MVOL_INT:  regRdata <= mvolInt;
            `APC_ADDR_MVOL_FRAC: regRdata <= {6'h00, mvolFrac};
            `APC_ADDR_CMUTE:     regRdata <= {{(8-NCH){1'b0}}, cmuteReg};
            default: begin
               regRdata <= 8'h00;
               for (j = 0; j < NCH; j = j + 1)
                  if (regAddr == `APC_ADDR_CVOL_A1 + j[6:0])
                     regRdata <= cvolInt[j];
            end
         endcase
      end
   end

   // ****************************************
   // freeze and config outputs
   // ****************************************
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mvolApplied       <= 10'h000;
         cmuteApplied      <= {NCH{1'b0}};
         deviceAwake       <= 1'b0;
         audioFormatSel    <= 3'h1;
         emphasisFilterSel <= 2'h0;
         amBandHopEn       <= 1'b0;
         dutyStrobeCnt     <= 8'h00;
         for (k = 0; k < NCH; k = k + 1)
            cvolApplied[k] <= 8'h00;
      end else begin
         if (!freeze) begin
            mvolApplied  <= {clampVol(mvolInt), mvolFrac};
            cmuteApplied <= cmuteReg;
            for (k = 0; k < NCH; k = k + 1)
               cvolApplied[k] <= clampVol(sharedLevel ? cvolInt[0] :
                                          cvolInt[k]);
         end
         deviceAwake       <= !globalSleep;
         audioFormatSel    <= miscReg[7:5];
         emphasisFilterSel <= miscReg[1:0];
         amBandHopEn       <= hopOn;
         dutyStrobeCnt     <= (dutyStrobeCnt >= strobeLast) ?
                              8'h00 : dutyStrobeCnt + 8'h01;
      end
   end

   // ****************************************
   // per channel level and output
   // ****************************************
   wire [STEP_W-1:0] stepCycles = stepFor(rampSpd);
   wire [TO_W-1:0]   zcTimeout  = hopOn ? ZC_FAST[TO_W-1:0] :
                                          ZC_SLOW[TO_W-1:0];
   wire [NCH-1:0]    posW;
   wire [NCH-1:0]    negW;
   // per channel applied levels, registered below
   wire [NCH*12-1:0] lvlAll;

   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : gCh
         wire        muted = cmuteApplied[g] | muteReq[g];
         // eighth-dB target: master quarter-dB doubled, channel dB x 8
         wire [11:0] vol   = {mvolApplied[9], mvolApplied, 1'b0} +
                             {cvolApplied[g][7], cvolApplied[g], 3'h0};
         wire [11:0] floorLvl = 12'hC08;
         wire [11:0] target   = muted ? floorLvl : vol;
         wire [11:0] lvl      = lvlAll[g*12 +: 12];
         wire        atFloor  = (lvl == floorLvl);
         wire [7:0]  sig      = audioDuty[g*8 +: 8];
         wire [7:0]  corr     = supplyCorr[g*8 +: 8];
         wire        fullMute = muted && atFloor && mute50;
         // exact half duty once muted at the floor with mute50 set, no rejection feedback while muted with mute50 set
         wire [7:0]  duty = fullMute ? `APC_DUTY_HALF :
                            (supplyRejectEn && !(muted && mute50)) ?
                            satAdd(sig, corr) : sig;
         apc_level_track #(.TO_W(TO_W)) uLvl (
            .refClk    (ref_clk),
            .resetN    (reset_n),
            .target    (target),
            .mode      (lcMode),
            .lrTick    (lrTick),
            .zeroCross (zeroCross[g]),
            .timeout   (zcTimeout),
            .level     (lvlAll[g*12 +: 12])
         );
         apc_chan_ramp #(.STEP_W(STEP_W)) uRamp (
            .refClk     (ref_clk),
            .resetN     (reset_n),
            .sleep      (globalSleep | chanPdnReg[g]),
            .offState   (offState),
            .rampSel    (rampSel),
            .stepCycles (stepCycles),
            .audioDuty  (duty),
            .dutyStrobe (dutyStrobe),
            .posPulse   (posW[g]),
            .negPulse   (negW[g]),
            .active     ()
         );
      end
   endgenerate

   // ****************************************
   // output registers
   // ****************************************
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         posPulseOut <= {NCH{1'b0}};
         negPulseOut <= {NCH{1'b0}};
         chanLevel   <= {NCH*12{1'b0}};
      end else begin
         posPulseOut <= posW;
         negPulseOut <= negW;
         chanLevel   <= lvlAll;
      end
   end

endmodule // apc_config_top

// >>> dv/apc_config_top_assertions.sv
// checker for the configuration bank, watching top ports only
// assumes the bind below onto apc_config_top
`timescale 1ns/1ns
module apc_config_top_assertions #(
   parameter NCH = 6
) (
   input wire           ref_clk,
   input wire           reset_n,
   input wire [6:0]     regAddr,
   input wire           regWrite,
   input wire           regRead,
   input wire [7:0]     regWdata,
   input wire [7:0]     regRdata,
   input wire [NCH-1:0] posPulseOut,
   input wire [NCH-1:0] negPulseOut,
   input wire           deviceAwake,
   input wire [2:0]     audioFormatSel,
   input wire [1:0]     emphasisFilterSel,
   input wire           amBandHopEn
);
   // ****
   // shadow of written power state
   // ****
   reg            offSt;
   reg  [NCH-1:0] chanSlp;
   reg            rampOff;
   reg  [2:0]     settle;
   wire           wrPwr;
   wire [NCH-1:0] slp;
   assign wrPwr = regWrite && (regAddr == 7'h02 || regAddr == 7'h03
                  || regAddr == 7'h05);
   assign slp = deviceAwake ? chanSlp : {NCH{1'b1}};
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         offSt <= 1'b0;
         chanSlp <= {NCH{1'b1}};
         rampOff <= 1'b1;
         settle <= 3'h0;
      end else begin
         if (regWrite && regAddr == 7'h02)
            offSt <= regWdata[1];
         if (regWrite && regAddr == 7'h03)
            chanSlp <= regWdata[NCH-1:0];
         if (regWrite && regAddr == 7'h05)
            rampOff <= (regWdata[4:3] == 2'h0);
         if (wrPwr)
            settle <= 3'h0;
         else if (settle != 3'h7)
            settle <= settle + 3'h1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // ****
   // properties
   // ****
   property p_awake;
      regWrite && regAddr == 7'h02 |->
         ##2 deviceAwake == !$past(regWdata[0], 2);
   endproperty
   a_awake: assert property (p_awake) else $error("awake flag wrong");
   property p_fmt;
      regWrite && regAddr == 7'h04 |->
         ##2 audioFormatSel == $past(regWdata[7:5], 2);
   endproperty
   a_fmt: assert property (p_fmt) else $error("format wrong");
   property p_hop;
      regWrite && regAddr == 7'h04 |->
         ##2 amBandHopEn == $past(regWdata[3], 2);
   endproperty
   a_hop: assert property (p_hop) else $error("hop flag wrong");
   property p_emph;
      regWrite && regAddr == 7'h04 |->
         ##2 emphasisFilterSel == $past(regWdata[1:0], 2);
   endproperty
   a_emph: assert property (p_emph) else $error("emphasis wrong");
   property p_low;
      settle == 3'h7 && rampOff && !offSt |-> ((posPulseOut | negPulseOut) & slp) == '0;
   endproperty
   a_low: assert property (p_low) else $error("sleep outputs not low");
   property p_inact;
      settle == 3'h7 && rampOff && offSt |-> (posPulseOut & slp) == '0 && (negPulseOut & slp) == slp;
   endproperty
   a_inact: assert property (p_inact) else $error("inactive state wrong");
   property p_run;
      settle == 3'h7 && rampOff |-> ((posPulseOut ^ negPulseOut) & ~slp) == ~slp;
   endproperty
   a_run: assert property (p_run) else $error("running pair not complementary");
   property p_unmap;
      regRead && regAddr > 7'h13 |=> regRdata == 8'h00;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_resv;
      regRead && regAddr == 7'h05 |=> (regRdata & 8'hE4) == 8'h00;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bits not zero");
   property p_hold;
      !regRead && !$past(regRead) |=> $stable(regRdata);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
endmodule // apc_config_top_assertions

bind apc_config_top apc_config_top_assertions #(.NCH(NCH)) u_chk (
   .ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr),
   .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
   .regRdata(regRdata), .posPulseOut(posPulseOut),
   .negPulseOut(negPulseOut), .deviceAwake(deviceAwake),
   .audioFormatSel(audioFormatSel), .emphasisFilterSel(emphasisFilterSel),
   .amBandHopEn(amBandHopEn)
);

// >>> dv/apc_config_top_bench.sv
// self-checking bench for the configuration bank
// assumes the checker file is compiled alongside
`timescale 1ns/1ns
module apc_config_top_bench;
   reg         ref_clk;
   reg         reset_n;
   reg  [6:0]  regAddr;
   reg         regWrite;
   reg         regRead;
   reg  [7:0]  regWdata;
   wire [7:0]  regRdata;
   reg         lrTick;
   reg  [5:0]  zeroCross;
   reg  [47:0] audioDuty;
   reg  [47:0] supplyCorr;
   reg         supplyRejectEn;
   reg  [5:0]  muteReq;
   wire [5:0]  posPulseOut;
   wire [5:0]  negPulseOut;
   wire        deviceAwake;
   wire [2:0]  audioFormatSel;
   wire [1:0]  emphasisFilterSel;
   wire        amBandHopEn;
   wire [71:0] chanLevel;
   integer     n_errors;
   integer     n_tests;
   integer     i;
   reg  [7:0]  rd;

   apc_config_top #(.ZC_SLOW(50), .ZC_FAST(40)) dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr),
      .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
      .regRdata(regRdata), .lrTick(lrTick), .zeroCross(zeroCross),
      .audioDuty(audioDuty), .supplyCorr(supplyCorr),
      .supplyRejectEn(supplyRejectEn), .muteReq(muteReq),
      .posPulseOut(posPulseOut), .negPulseOut(negPulseOut),
      .deviceAwake(deviceAwake), .audioFormatSel(audioFormatSel),
      .emphasisFilterSel(emphasisFilterSel), .amBandHopEn(amBandHopEn),
      .chanLevel(chanLevel)
   );

   // ****
   // access tasks
   // ****
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [6:0] a, input [7:0] d);
      begin
         @(negedge ref_clk);
         regAddr = a;
         regWdata = d;
         regWrite = 1'b1;
         @(negedge ref_clk);
         regWrite = 1'b0;
         repeat (3) @(negedge ref_clk);
      end
   endtask
   task rdc(input [6:0] a, input [7:0] m, input [7:0] exp);
      begin
         @(negedge ref_clk);
         regAddr = a;
         regRead = 1'b1;
         @(negedge ref_clk);
         regRead = 1'b0;
         @(negedge ref_clk);
         chk(regRdata & m, exp);
      end
   endtask
   task pulse(input tk, input [5:0] zc);
      begin
         @(negedge ref_clk);
         lrTick = tk;
         zeroCross = zc;
         @(negedge ref_clk);
         lrTick = 1'b0;
         zeroCross = 6'h00;
         repeat (2) @(negedge ref_clk);
      end
   endtask
   task report_and_stop;
      begin
         $display("errors %0d compares %0d", n_errors, n_tests);
         if (n_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      #100000;
      n_errors = n_errors + 1;
      $display("[FAIL] %0t watchdog expired", $time);
      report_and_stop;
   end

   // ****
   // scenarios
   // ****
   initial begin
      n_errors = 0;
      n_tests = 0;
      reset_n = 1'b0;
      regAddr = 7'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      regWdata = 8'h00;
      lrTick = 1'b0;
      zeroCross = 6'h00;
      audioDuty = {6{8'h80}};
      supplyCorr = {6{8'h04}};
      supplyRejectEn = 1'b1;
      muteReq = 6'h00;
      repeat (8) @(negedge ref_clk);
      reset_n = 1'b1;
      @(negedge ref_clk);
      chk(deviceAwake, 1'b0);
      chk(audioFormatSel, 3'h1);
      chk(emphasisFilterSel, 2'h0);
      chk({posPulseOut, negPulseOut}, 12'h000);
      rdc(7'h02, 8'h03, 8'h01);
      rdc(7'h03, 8'h3F, 8'h3F);
      rdc(7'h04, 8'hFF, 8'h20);
      rdc(7'h05, 8'hFF, 8'h01);
      rdc(7'h06, 8'hE8, 8'h40);
      // every format and emphasis code, hop set while asleep
      for (i = 0; i < 8; i = i + 1) begin
         wr(7'h04, {i[2:0], 2'h3, 1'b0, i[1:0]});
         chk(audioFormatSel, i[2:0]);
         chk(emphasisFilterSel, i[1:0]);
         chk(amBandHopEn, 1'b1);
         rdc(7'h04, 8'hFF, {i[2:0], 2'h1, 1'b0, i[1:0]});
      end
      wr(7'h04, 8'h20);
      wr(7'h05, 8'hFF);
      rdc(7'h05, 8'hFF, 8'h1B);
      wr(7'h05, 8'h01);
      wr(7'h7F, 8'hFF);
      rdc(7'h7F, 8'hFF, 8'h00);
      // sleep drive, then one channel awake
      wr(7'h02, 8'h03);
      chk(negPulseOut, 6'h3F);
      chk(posPulseOut, 6'h00);
      wr(7'h02, 8'h00);
      wr(7'h03, 8'h3E);
      chk(deviceAwake, 1'b1);
      chk({posPulseOut[5:1], negPulseOut[5:1]}, 10'h000);
      chk(posPulseOut[0] ^ negPulseOut[0], 1'b1);
      rdc(7'h03, 8'h3F, 8'h3E);
      wr(7'h02, 8'h02);
      wr(7'h03, 8'h3F);
      chk({posPulseOut[0], negPulseOut[0]}, 2'h1);
      wr(7'h02, 8'h00);
      wr(7'h03, 8'h00);
      // level paths
      wr(7'h06, 8'h00);
      wr(7'h09, 8'hFF);
      chk(chanLevel[23:0], 24'h000FF8);
      wr(7'h04, 8'h24);
      wr(7'h09, 8'hFE);
      wr(7'h0A, 8'hFD);
      chk(chanLevel[23:0], 24'h000FF8);
      wr(7'h04, 8'h20);
      chk(chanLevel[23:0], 24'hFE8FF0);
      wr(7'h06, 8'h80);
      chk(chanLevel[23:12], 12'hFF0);
      wr(7'h06, 8'h40);
      wr(7'h09, 8'hFF);
      chk(chanLevel[11:0], 12'hFF0);
      pulse(1'b1, 6'h00);
      chk(chanLevel[11:0], 12'hFF1);
      repeat (7) pulse(1'b1, 6'h00);
      chk(chanLevel[11:0], 12'hFF8);
      wr(7'h06, 8'h20);
      wr(7'h09, 8'hFE);
      chk(chanLevel[11:0], 12'hFF8);
      pulse(1'b0, 6'h01);
      chk(chanLevel[11:0], 12'hFF0);
      wr(7'h09, 8'hFF);
      repeat (16) @(negedge ref_clk);
      chk(chanLevel[11:0], 12'hFF0);
      repeat (40) @(negedge ref_clk);
      chk(chanLevel[11:0], 12'hFF8);
      wr(7'h06, 8'h60);
      wr(7'h09, 8'hFE);
      pulse(1'b0, 6'h01);
      chk(chanLevel[11:0], 12'hFF7);
      wr(7'h06, 8'h08);
      chk(chanLevel[11:0], 12'hFF0);
      muteReq = 6'h01;
      repeat (4) @(negedge ref_clk);
      chk(chanLevel[11:0], 12'hC08);
      wr(7'h06, 8'h00);
      muteReq = 6'h00;
      repeat (4) @(negedge ref_clk);
      chk(chanLevel[11:0], 12'hFF0);
      report_and_stop;
   end
endmodule // apc_config_top_bench
